// File: t16_map.vh
// Register map, field positions, mode codes and constants of the timer
`ifndef T16_MAP_VH
`define T16_MAP_VH

// Byte offsets on the APB bus
`define T16_OFF_WOC        8'h00
`define T16_OFF_TCS        8'h04
`define T16_OFF_PEN        8'h08
`define T16_OFF_CNT        8'h0C
`define T16_OFF_CMPA       8'h10
`define T16_OFF_CMPB       8'h14
`define T16_OFF_CAP        8'h18
`define T16_OFF_FLAGS      8'h1C

// Reset values
`define T16_RST_8          8'h00
`define T16_RST_16         16'h0000

// waveform_output_control fields
`define T16_WOC_CHA_HI     7
`define T16_WOC_CHA_LO     6
`define T16_WOC_CHB_HI     5
`define T16_WOC_CHB_LO     4
`define T16_WOC_RSVD_MASK  8'hF3
`define T16_WOC_WGM_HI     1
`define T16_WOC_WGM_LO     0

// timer_control_second fields
`define T16_TCS_WGM_HI     4
`define T16_TCS_WGM_LO     3
`define T16_TCS_CS_HI      2
`define T16_TCS_CS_LO      0
`define T16_TCS_MASK       8'hDF

// Flag register bits, write one to clear
`define T16_FLG_OVF        0
`define T16_FLG_MATCH_A    1
`define T16_FLG_MATCH_B    2
`define T16_FLG_CAP        3

// Waveform modes
`define T16_MODE_PFC_CAP   4'h8
`define T16_MODE_PC_CAP    4'hA
`define T16_MODE_CLR_CAP   4'hC
`define T16_MODE_RSVD      4'hD
`define T16_MODE_FAST_CAP  4'hE

// Mode classes
`define T16_CL_NONPWM      2'h0
`define T16_CL_FAST        2'h1
`define T16_CL_PC          2'h2
`define T16_CL_PFC         2'h3

// Top sources
`define T16_TOP_MAX        2'h0
`define T16_TOP_FIXED      2'h1
`define T16_TOP_CMPA       2'h2
`define T16_TOP_CAP        2'h3

// Count limits
`define T16_MAX            16'hFFFF
`define T16_BOTTOM         16'h0000
`define T16_TOP_8BIT       16'h00FF
`define T16_TOP_9BIT       16'h01FF
`define T16_TOP_10BIT      16'h03FF

// Output actions
`define T16_ACT_OFF        2'h0
`define T16_ACT_TOG        2'h1
`define T16_ACT_CLR        2'h2
`define T16_ACT_SET        2'h3

// Tick source selections
`define T16_CS_STOP        3'h0
`define T16_CS_DIV1        3'h1
`define T16_CS_DIV8        3'h2
`define T16_CS_DIV64       3'h3
`define T16_CS_DIV256      3'h4
`define T16_CS_DIV1024     3'h5
`define T16_CS_EXT_FALL    3'h6
`define T16_CS_EXT_RISE    3'h7

// Prescaler terminal counts (divide ratio minus one)
`define T16_PS_W           10
`define T16_PS_END8        10'h007
`define T16_PS_END64       10'h03F
`define T16_PS_END256      10'h0FF
`define T16_PS_END1024     10'h3FF

`endif

// File: t16_pin_load.sv
// External load on the port pins, pulled up where not driven
`timescale 1ns/1ns
module t16_pin_load (
  // From the timer
  input  wire [7:0] i_pin_out,
  input  wire [7:0] i_pin_oe,
  // Level seen on the wire
  output wire [7:0] o_pin_lvl
);
  // Undriven pins float to the pull-up, never to stale data
  assign o_pin_lvl = (i_pin_out & i_pin_oe) | ~i_pin_oe;
endmodule // t16_pin_load

// File: t16_prescale.v
// Tick source: free prescaler and external pin edge detector
`timescale 1ns/1ns
module t16_prescale (
  // Clock and reset
  input  wire        i_mclk,
  input  wire        i_srst,
  // Control
  input  wire [2:0]  i_tick_source_select,
  input  wire        i_ext_clk,
  // Tick out
  output reg         o_timer_tick
);
`include "t16_map.vh"

  reg [`T16_PS_W-1:0] ps_cnt_r;
  reg                 ext_prev_r;
  wire                ext_rise;
  wire                ext_fall;

  // Shared prescaler runs freely, so a divider change is not phase aligned
  always @(posedge i_mclk) begin
    if (i_srst) begin
      ps_cnt_r   <= {`T16_PS_W{1'b0}};
      ext_prev_r <= 1'b0;
    end else begin
      ps_cnt_r   <= ps_cnt_r + 10'h001;
      ext_prev_r <= i_ext_clk;
    end
  end

  assign ext_rise = i_ext_clk & ~ext_prev_r;
  assign ext_fall = ~i_ext_clk & ext_prev_r;

  always @* begin
    case (i_tick_source_select) // RULE_18
      `T16_CS_STOP:     o_timer_tick = 1'b0;
      `T16_CS_DIV1:     o_timer_tick = 1'b1;
      `T16_CS_DIV8:
        o_timer_tick = ({7'h00, ps_cnt_r[2:0]} == `T16_PS_END8);
      `T16_CS_DIV64:
        o_timer_tick = ({4'h0, ps_cnt_r[5:0]} == `T16_PS_END64);
      `T16_CS_DIV256:
        o_timer_tick = ({2'h0, ps_cnt_r[7:0]} == `T16_PS_END256);
      `T16_CS_DIV1024:  o_timer_tick = (ps_cnt_r == `T16_PS_END1024);
      `T16_CS_EXT_FALL: o_timer_tick = ext_fall;
      `T16_CS_EXT_RISE: o_timer_tick = ext_rise;
      default:          o_timer_tick = 1'b0;
    endcase
  end

endmodule // t16_prescale

// File: t16_timer.v
// Sixteen-bit timer with waveform modes, compare outputs and APB registers
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns
// Functional notes
// (RULE_01) Synchronous logic; tick only enables counting events
// (RULE_02) Nonzero action connects channel output; A 7:6, B 5:4
// (RULE_03) Pin driven only with direction and enable set
// (RULE_04) Enable off or action 00: normal port
// (RULE_05) Non-PWM: 01 toggle, 10 clear, 11 set
// (RULE_06) PWM 01: toggle A if mode bit high
// (RULE_07) Fast PWM: match clear/set, top opposite
// (RULE_08) Fast PWM compare equals top: top action only
// (RULE_09) Dual slope: action flips with count direction
// (RULE_10) Control bits 3:2 reserved, no function
// (RULE_11) Four-bit mode from two registers' fields
// (RULE_12) Modes 0,4,12: immediate update, overflow at max
// (RULE_13) Modes 1-3: phase correct fixed tops
// (RULE_14) Fast PWM modes 5-7,14,15; 13 reserved
// (RULE_15) Modes 8,9: phase-frequency correct, bottom update
// (RULE_16) Modes 10,11: phase correct, top update
// (RULE_17) Capture as top disconnects capture input
// (RULE_18) Three-bit tick source select with prescaler
// (RULE_19) Flags and top detection only on ticks; the capture flag sets on any capture event, tick or not, unless capture is top
module t16_timer (
  // Clock and reset
  input  wire        i_mclk,
  input  wire        i_srst,
  // APB slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output wire        o_pready,
  output wire        o_pslverr,
  // Port pins, A on 3:0 and B on 7:4
  input  wire [7:0]  i_port_out,
  input  wire [7:0]  i_port_dir,
  output wire [7:0]  o_pin_out,
  output wire [7:0]  o_pin_oe,
  // External tick and capture source
  input  wire        i_ext_clk,
  input  wire        i_capture_evt,
  input  wire [15:0] i_capture_val,
  // Status
  output wire        o_timer_tick,
  output wire        o_capture_pin_off,
  output wire        o_overflow_flag,
  output wire [1:0]  o_match_flags,
  output wire        o_capture_flag
);
`include "t16_map.vh"

  // Mode class of a waveform mode
  function [1:0] mode_class;
    input [3:0] m;
    begin
      case (m) // RULE_11
        4'h1, 4'h2, 4'h3, 4'hA, 4'hB: mode_class = `T16_CL_PC;
        4'h5, 4'h6, 4'h7, 4'hE, 4'hF: mode_class = `T16_CL_FAST;
        4'h8, 4'h9:                   mode_class = `T16_CL_PFC;
        default:                      mode_class = `T16_CL_NONPWM;
      endcase
    end
  endfunction

  // Top source of a waveform mode
  function [1:0] top_source;
    input [3:0] m;
    begin
      case (m)
        4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7: top_source = `T16_TOP_FIXED;
        4'h4, 4'h9, 4'hB, 4'hF:             top_source = `T16_TOP_CMPA;
        4'h8, 4'hA, 4'hC, 4'hE:             top_source = `T16_TOP_CAP;
        default:                            top_source = `T16_TOP_MAX;
      endcase
    end
  endfunction

  // Registers
  reg  [7:0]  woc_r;
  reg  [7:0]  tcs_r;
  reg  [7:0]  pen_r;
  reg  [15:0] cnt_r;
  reg  [15:0] cnt_nxt;
  reg         down_r;
  reg         down_nxt;
  reg  [15:0] cmpa_r;
  reg  [15:0] cmpb_r;
  reg  [15:0] cmpa_buf_r;
  reg  [15:0] cmpb_buf_r;
  reg  [15:0] cap_r;
  reg  [3:0]  flags_r;
  reg         blk_r;

  // Decoded state
  wire [3:0]  mode;
  wire [1:0]  mclass;
  wire [1:0]  tsrc;
  reg  [15:0] top;
  wire        tick;
  wire        at_top;
  wire        at_bottom;
  wire        cap_is_top;
  reg         ovf_evt;
  reg         load_evt;
  reg         top_evt;
  wire [1:0]  match_evt;
  wire [1:0]  cmp_is_top;
  wire [1:0]  connect;
  wire [1:0]  wave;
  wire [1:0]  action [0:1];

  // Bus decode
  wire        setup;
  wire        access;
  wire        wr;
  reg         mapped;
  reg  [31:0] rd_mux;

  assign mode = {tcs_r[`T16_TCS_WGM_HI:`T16_TCS_WGM_LO],
                 woc_r[`T16_WOC_WGM_HI:`T16_WOC_WGM_LO]}; // RULE_11
  assign mclass = mode_class(mode);
  assign tsrc   = top_source(mode);

  always @* begin
    case (tsrc)
      `T16_TOP_FIXED: begin
        case (woc_r[`T16_WOC_WGM_HI:`T16_WOC_WGM_LO]) // RULE_13 RULE_14
          2'h1:    top = `T16_TOP_8BIT;
          2'h2:    top = `T16_TOP_9BIT;
          default: top = `T16_TOP_10BIT;
        endcase
      end
      `T16_TOP_CMPA: top = cmpa_r; // RULE_12 RULE_15 RULE_16
      `T16_TOP_CAP:  top = cap_r;
      default:       top = `T16_MAX; // RULE_12
    endcase
  end

  assign cap_is_top        = (tsrc == `T16_TOP_CAP);
  assign o_capture_pin_off = cap_is_top; // RULE_17
  assign at_top            = (cnt_r == top);
  assign at_bottom         = (cnt_r == `T16_BOTTOM);

  t16_prescale u_prescale (
    .i_mclk               (i_mclk),
    .i_srst               (i_srst),
    .i_tick_source_select (tcs_r[`T16_TCS_CS_HI:`T16_TCS_CS_LO]),
    .i_ext_clk            (i_ext_clk),
    .o_timer_tick         (tick)
  );
  assign o_timer_tick = tick;

  assign setup  = i_psel & ~i_penable;
  assign access = i_psel & i_penable;
  assign wr     = access & i_pwrite & mapped;

  // Count sequence, events gated by the tick
  always @* begin
    cnt_nxt  = cnt_r;
    down_nxt = down_r;
    ovf_evt  = 1'b0;
    load_evt = 1'b0;
    top_evt  = 1'b0;
    if (tick) begin // RULE_01 RULE_19
      top_evt = at_top;
      case (mclass)
        `T16_CL_NONPWM: begin
          cnt_nxt = at_top ? `T16_BOTTOM : cnt_r + 16'h0001;
          ovf_evt = (cnt_r == `T16_MAX); // RULE_12
        end
        `T16_CL_FAST: begin
          cnt_nxt  = at_top ? `T16_BOTTOM : cnt_r + 16'h0001;
          ovf_evt  = at_top; // RULE_14
          load_evt = at_top;
        end
        default: begin
          if (!down_r) begin
            down_nxt = at_top;
            cnt_nxt  = at_top ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
          end else begin
            down_nxt = ~at_bottom;
            cnt_nxt  = at_bottom ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
          end
          ovf_evt = at_bottom; // RULE_13 RULE_15 RULE_16
          if (mclass == `T16_CL_PFC)
            load_evt = at_bottom; // RULE_15
          else
            load_evt = at_top; // RULE_13 RULE_16
        end
      endcase
    end
    if (wr && (i_paddr == `T16_OFF_CNT)) begin
      cnt_nxt = i_pwdata[15:0];
    end
  end

  // A written count suppresses the match at the next tick
  assign match_evt[0] = tick & ~blk_r & (cnt_r == cmpa_r); // RULE_19
  assign match_evt[1] = tick & ~blk_r & (cnt_r == cmpb_r); // RULE_19
  assign cmp_is_top[0] = (cmpa_r == top);
  assign cmp_is_top[1] = (cmpb_r == top);
  assign action[0] = woc_r[`T16_WOC_CHA_HI:`T16_WOC_CHA_LO]; // RULE_02
  assign action[1] = woc_r[`T16_WOC_CHB_HI:`T16_WOC_CHB_LO]; // RULE_02

  genvar ch;
  genvar pn;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      t16_wave_out #(
        .IS_A (ch == 0)
      ) u_wave (
        .i_mclk       (i_mclk),
        .i_srst       (i_srst),
        .i_match      (match_evt[ch]),
        .i_top_evt    (top_evt),
        .i_cnt_down   (down_r),
        .i_cmp_is_top (cmp_is_top[ch]),
        .i_class      (mclass),
        .i_action     (action[ch]),
        .i_mode_hi    (mode[3]),
        .o_wave       (wave[ch]),
        .o_connect    (connect[ch])
      );
    end
    for (pn = 0; pn < 8; pn = pn + 1) begin : g_pin
      // Override only where the pin enable is set too
      assign o_pin_out[pn] = (connect[pn/4] & pen_r[pn]) ?
                             wave[pn/4] : i_port_out[pn]; // RULE_02 RULE_04
      assign o_pin_oe[pn]  = i_port_dir[pn]; // RULE_03
    end
  endgenerate

  // Register file and counter state
  always @(posedge i_mclk) begin
    if (i_srst) begin
      woc_r      <= `T16_RST_8;
      tcs_r      <= `T16_RST_8;
      pen_r      <= `T16_RST_8;
      cnt_r      <= `T16_RST_16;
      down_r     <= 1'b0;
      cmpa_r     <= `T16_RST_16;
      cmpb_r     <= `T16_RST_16;
      cmpa_buf_r <= `T16_RST_16;
      cmpb_buf_r <= `T16_RST_16;
      cap_r      <= `T16_RST_16;
      flags_r    <= 4'h0;
      blk_r      <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      down_r <= down_nxt;
      if (wr && (i_paddr == `T16_OFF_CNT))
        blk_r <= 1'b1;
      else if (tick)
        blk_r <= 1'b0;
      if (wr) begin
        case (i_paddr)
          `T16_OFF_WOC: woc_r <= i_pwdata[7:0] & `T16_WOC_RSVD_MASK; // RULE_10
          `T16_OFF_TCS: tcs_r <= i_pwdata[7:0] & `T16_TCS_MASK;
          `T16_OFF_PEN: pen_r <= i_pwdata[7:0];
          `T16_OFF_CMPA: cmpa_buf_r <= i_pwdata[15:0];
          `T16_OFF_CMPB: cmpb_buf_r <= i_pwdata[15:0];
          `T16_OFF_CAP: cap_r <= i_pwdata[15:0];
          default: ;
        endcase
      end else if (i_capture_evt && !cap_is_top) begin
        cap_r <= i_capture_val; // RULE_17
      end
      // Double buffering only in PWM classes
      if (mclass == `T16_CL_NONPWM) begin
        cmpa_r <= cmpa_buf_r; // RULE_12
        cmpb_r <= cmpb_buf_r;
      end else if (load_evt) begin
        cmpa_r <= cmpa_buf_r; // RULE_13 RULE_14 RULE_15 RULE_16
        cmpb_r <= cmpb_buf_r;
      end
      // Hardware set wins over a same-cycle clear
      if (wr && (i_paddr == `T16_OFF_FLAGS))
        flags_r <= flags_r & ~i_pwdata[3:0];
      if (ovf_evt)
        flags_r[`T16_FLG_OVF] <= 1'b1; // RULE_19
      if (match_evt[0])
        flags_r[`T16_FLG_MATCH_A] <= 1'b1; // RULE_19
      if (match_evt[1])
        flags_r[`T16_FLG_MATCH_B] <= 1'b1; // RULE_19
      if ((cap_is_top && top_evt) || (i_capture_evt && !cap_is_top))
        flags_r[`T16_FLG_CAP] <= 1'b1;
    end
  end

  // Read mux
  always @* begin
    mapped = 1'b1;
    rd_mux = 32'h00000000;
    case (i_paddr)
      `T16_OFF_WOC:   rd_mux[7:0]  = woc_r;
      `T16_OFF_TCS:   rd_mux[7:0]  = tcs_r;
      `T16_OFF_PEN:   rd_mux[7:0]  = pen_r;
      `T16_OFF_CNT:   rd_mux[15:0] = cnt_r;
      `T16_OFF_CMPA:  rd_mux[15:0] = cmpa_buf_r;
      `T16_OFF_CMPB:  rd_mux[15:0] = cmpb_buf_r;
      `T16_OFF_CAP:   rd_mux[15:0] = cap_r;
      `T16_OFF_FLAGS: rd_mux[3:0]  = flags_r;
      default:        mapped = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle, valid through access
  always @(posedge i_mclk) begin
    if (i_srst)
      o_prdata <= 32'h00000000;
    else if (setup)
      o_prdata <= i_pwrite ? 32'h00000000 : rd_mux;
  end

  assign o_pready  = access;
  assign o_pslverr = access & ~mapped;

  assign o_overflow_flag = flags_r[`T16_FLG_OVF];
  assign o_match_flags   = flags_r[`T16_FLG_MATCH_B:`T16_FLG_MATCH_A];
  assign o_capture_flag  = flags_r[`T16_FLG_CAP];

endmodule // t16_timer

// File: t16_timer_chk_sva.sv
// Checker on the timer ports: pin muxing, tick source and flag timing
`timescale 1ns/1ns
`include "t16_map.vh"
module t16_timer_chk (
  // Clock, reset and APB
  input wire        i_mclk,
  input wire        i_srst,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [7:0]  i_paddr,
  input wire [31:0] i_pwdata,
  // Pins and status
  input wire [7:0]  i_port_out,
  input wire [7:0]  i_port_dir,
  input wire [7:0]  o_pin_out,
  input wire [7:0]  o_pin_oe,
  input wire        o_timer_tick,
  input wire        o_capture_pin_off,
  input wire        o_overflow_flag,
  input wire [1:0]  o_match_flags
);
  // Control bytes snooped from APB writes
  logic [7:0] woc_r, tcs_r, pen_r, dis_r;
  wire  [3:0] mode = {tcs_r[4:3], woc_r[1:0]};
  wire  [2:0] cs = tcs_r[2:0];
  wire        pwm = !(mode inside {4'h0, 4'h4, 4'hC, 4'hD});
  wire  [7:0] dis = {~pen_r[7:4] | {4{woc_r[5:4] == 2'h0}},
                     ~pen_r[3:0] | {4{woc_r[7:6] == 2'h0}}};
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  always @(posedge i_mclk) begin
    dis_r <= i_srst ? 8'hFF : dis;
    if (i_srst) begin
      woc_r <= 8'h00;
      tcs_r <= 8'h00;
      pen_r <= 8'h00;
    end else if (i_psel && i_penable && i_pwrite) begin
      if (i_paddr == `T16_OFF_WOC) woc_r <= i_pwdata[7:0];
      if (i_paddr == `T16_OFF_TCS) tcs_r <= i_pwdata[7:0];
      if (i_paddr == `T16_OFF_PEN) pen_r <= i_pwdata[7:0];
    end
  end
  sequence s_cs_held(logic [2:0] v);
    cs == v ##1 cs == v;
  endsequence
  // Connect may lag a config write by one clock
  sequence s_cfg_held;
    $stable(woc_r) && $stable(tcs_r);
  endsequence
  a_oe_from_dir: assert property (o_pin_oe == i_port_dir)
    else $error("pin enable differs from direction");
  a_pin_normal: assert property (
    ((o_pin_out ^ i_port_out) & dis & dis_r) == 8'h00)
    else $error("disconnected pin does not follow port data");
  a_pwm_tog_off: assert property (s_cfg_held ##0
    (pwm && !mode[3] && woc_r[7:6] == 2'h1)
    |-> o_pin_out[3:0] == i_port_out[3:0])
    else $error("pwm toggle action connected the pin");
  a_cap_pin_off: assert property ($stable(mode) |->
    o_capture_pin_off == (mode[3] && !mode[0]))
    else $error("capture pin state wrong for mode");
  a_tick_every: assert property (s_cs_held(3'h1) |-> o_timer_tick)
    else $error("undivided tick missing");
  a_tick_stop: assert property (s_cs_held(3'h0) |-> !o_timer_tick)
    else $error("tick while stopped");
  a_div8_gap: assert property (s_cs_held(3'h2) ##0 o_timer_tick
    |=> !o_timer_tick [*7])
    else $error("divide by eight tick too early");
  a_ovf_on_tick: assert property (
    $rose(o_overflow_flag) |-> $past(o_timer_tick))
    else $error("overflow flag set without tick");
  a_match_on_tick: assert property (
    $rose(o_match_flags[0]) || $rose(o_match_flags[1])
    |-> $past(o_timer_tick))
    else $error("match flag set without tick");
endmodule // t16_timer_chk

bind t16_timer t16_timer_chk u_chk (
  .i_mclk(i_mclk), .i_srst(i_srst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .i_port_out(i_port_out), .i_port_dir(i_port_dir),
  .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_timer_tick(o_timer_tick),
  .o_capture_pin_off(o_capture_pin_off),
  .o_overflow_flag(o_overflow_flag), .o_match_flags(o_match_flags)
);

// File: t16_wave_out.v
// One compare channel's waveform generator and pin connect decision
`timescale 1ns/1ns
module t16_wave_out #(
  parameter IS_A = 1
) (
  // Clock and reset
  input  wire        i_mclk,
  input  wire        i_srst,
  // Qualified events
  input  wire        i_match,
  input  wire        i_top_evt,
  input  wire        i_cnt_down,
  input  wire        i_cmp_is_top,
  // Configuration
  input  wire [1:0]  i_class,
  input  wire [1:0]  i_action,
  input  wire        i_mode_hi,
  // Result
  output reg         o_wave,
  output reg         o_connect
);
`include "t16_map.vh"

  wire pwm;
  wire tog_ok;

  assign pwm    = (i_class != `T16_CL_NONPWM);
  // Toggle in PWM only on channel A with the top mode bit set
  assign tog_ok = (IS_A != 0) & i_mode_hi; // RULE_06

  always @* begin
    if (i_action == `T16_ACT_OFF)
      o_connect = 1'b0; // RULE_04
    else if (pwm && (i_action == `T16_ACT_TOG))
      o_connect = tog_ok; // RULE_06
    else
      o_connect = 1'b1; // RULE_02
  end

  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_wave <= 1'b0;
    end else begin
      case (i_class)
        `T16_CL_NONPWM: begin
          if (i_match) begin
            case (i_action) // RULE_05
              `T16_ACT_TOG: o_wave <= ~o_wave;
              `T16_ACT_CLR: o_wave <= 1'b0;
              `T16_ACT_SET: o_wave <= 1'b1;
              default:      o_wave <= o_wave;
            endcase
          end
        end
        `T16_CL_FAST: begin
          if (i_action == `T16_ACT_TOG) begin
            if (i_match && tog_ok)
              o_wave <= ~o_wave; // RULE_06
          end else if (i_action[1]) begin
            // Clear action sets at top and clears on match; set reverses
            if (i_top_evt)
              o_wave <= ~i_action[0]; // RULE_07
            else if (i_match && !i_cmp_is_top) // RULE_08
              o_wave <= i_action[0]; // RULE_07
          end
        end
        default: begin
          if (i_action == `T16_ACT_TOG) begin
            if (i_match && tog_ok)
              o_wave <= ~o_wave; // RULE_06
          end else if (i_action[1] && i_match) begin
            // Up: CLR drives low, SET high; down reverses
            o_wave <= i_action[0] ^ i_cnt_down; // RULE_09
          end
        end
      endcase
    end
  end

endmodule // t16_wave_out

// File: tb_top.sv
// Self-checking bench for the sixteen-bit timer
`timescale 1ns/1ns
`include "t16_map.vh"
module tb_top;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ext = 0, cev = 0;
  logic [15:0] cval = 16'h0000;
  logic [7:0]  paddr = 8'h00, pout = 8'hFF, pdir = 8'hFF;
  logic [31:0] pwd = 32'h0, rd;
  logic        err_seen;
  wire  [31:0] prdata;
  wire  [7:0]  pin_out, pin_oe, lvl;
  wire         prdy, perr, tick, ovf, cflg;
  int          err_total = 0, check_count = 0, n, i, k;
  // Register rows: offset, write value, readback
  logic [7:0]  ra [8] = '{`T16_OFF_WOC, `T16_OFF_TCS, `T16_OFF_PEN,
    `T16_OFF_CNT, `T16_OFF_CMPA, `T16_OFF_CMPB, `T16_OFF_CAP, 8'h20};
  logic [31:0] rw [8] = '{32'hFF, 32'hFF, 32'hA5, 32'hBEEF, 32'h1234,
    32'h5678, 32'h9ABC, 32'hFF};
  logic [31:0] rx [8] = '{32'hF3, 32'hDF, 32'hA5, 32'hBEEF, 32'h1234,
    32'h5678, 32'h9ABC, 32'h0};
  // Waveform rows: mode, action, compare, window, high cycles
  logic [3:0]  md [16] = '{4'h4, 4'h4, 4'h4, 4'hC, 4'h5, 4'h5, 4'h5,
    4'h6, 4'hE, 4'hF, 4'h1, 4'h1, 4'h8, 4'hA, 4'hB, 4'h1};
  logic [1:0]  ac [16] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3, 2'h2,
    2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h2, 2'h3, 2'h1, 2'h1};
  logic [15:0] cm [16] = '{16'h9, 16'h9, 16'h9, 16'h3F, 16'h40, 16'h40,
    16'hFF, 16'h40, 16'h10, 16'h3F, 16'h40, 16'h40, 16'h10, 16'h10,
    16'h3F, 16'h40};
  int pr [16] = '{20, 20, 20, 128, 256, 256, 256, 512, 64, 64, 510, 510,
    126, 126, 252, 510};
  int hi [16] = '{10, 0, 20, 64, 65, 191, 256, 65, 17, 64, 128, 382, 32,
    94, 126, 510};
  int dv [4] = '{8, 64, 256, 1024};
  always #5 clk = ~clk;
  t16_timer DUT (
    .i_mclk(clk), .i_srst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prdata),
    .o_pready(prdy), .o_pslverr(perr), .i_port_out(pout),
    .i_port_dir(pdir), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .i_ext_clk(ext), .i_capture_evt(cev), .i_capture_val(cval),
    .o_timer_tick(tick), .o_capture_pin_off(), .o_overflow_flag(ovf),
    .o_match_flags(), .o_capture_flag(cflg)
  );
  t16_pin_load u_load (.i_pin_out(pin_out), .i_pin_oe(pin_oe),
    .o_pin_lvl(lvl));
  task check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Idle edge first, so back-to-back calls never reassign a strobe
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prdata;
    err_seen = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task test_done;
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    test_done;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      apb(1'b0, ra[i], 32'h0);
      check("reset value", rd, 32'h0);
    end
    for (i = 0; i < 8; i++) begin
      wr(ra[i], rw[i]);
      apb(1'b0, ra[i], 32'h0);
      check("readback", rd, rx[i]);
      check("slave error", err_seen, i == 7);
    end
    wr(`T16_OFF_TCS, 32'h0);
    wr(`T16_OFF_PEN, 32'h0F);
    wr(`T16_OFF_CAP, 32'h3F);
    for (i = 0; i < 16; i++) begin
      wr(`T16_OFF_TCS, 32'h0);
      wr(`T16_OFF_WOC, {24'h0, ac[i], 4'h0, md[i][1:0]});
      wr(`T16_OFF_CMPA, {16'h0, cm[i]});
      wr(`T16_OFF_CNT, 32'h0);
      wr(`T16_OFF_TCS, {27'h0, md[i][3:2], 3'h1});
      repeat (2 * pr[i]) @(posedge clk);
      n = 0;
      repeat (pr[i]) begin
        @(posedge clk);
        n += (lvl[0] === 1'b1);
      end
      check("pwm high", n, hi[i]);
    end
    for (i = 0; i < 4; i++) begin
      wr(`T16_OFF_TCS, {29'h0, 3'(i + 2)});
      repeat (2) @(posedge clk);
      n = 0;
      repeat (4 * dv[i]) begin
        @(posedge clk);
        n += (tick === 1'b1);
      end
      check("prescaled ticks", n, 4);
    end
    wr(`T16_OFF_TCS, 32'h0);
    for (i = 6; i < 8; i++) begin
      wr(`T16_OFF_TCS, {29'h0, 3'(i)});
      n = 0;
      for (k = 0; k < 48; k++) begin
        @(posedge clk);
        n += (tick === 1'b1);
        ext <= (k % 8 < 4) && (k < 40);
      end
      check("pin ticks", n, 5);
    end
    wr(`T16_OFF_TCS, 32'h0);
    wr(`T16_OFF_WOC, 32'h0);
    wr(`T16_OFF_FLAGS, 32'hF);
    wr(`T16_OFF_CNT, 32'hFFF0);
    wr(`T16_OFF_TCS, 32'h1);
    n = 0;
    // Sampled mid-cycle: 15 ticks to the maximum, flag one clock later
    while (ovf !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check("overflow flag", ovf, 1'b1);
    check("overflow at max", n, 17);
    apb(1'b0, `T16_OFF_FLAGS, 32'h0);
    check("flag read", rd & 32'h1, 32'h1);
    wr(`T16_OFF_FLAGS, 32'h1);
    apb(1'b0, `T16_OFF_FLAGS, 32'h0);
    check("flag clear", rd & 32'h1, 32'h0);
    // Capture loads in mode 0, is ignored once capture is top
    for (k = 0; k < 2; k++) begin
      cval <= k ? 16'h2468 : 16'h1357;
      cev <= 1'b1;
      @(posedge clk);
      cev <= 1'b0;
      apb(1'b0, `T16_OFF_CAP, 32'h0);
      check("capture value", rd, 32'h1357);
      wr(`T16_OFF_TCS, 32'h18);
    end
    check("capture flag", cflg, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `T16_OFF_TCS, 32'h0);
    check("mid-run reset", rd, 32'h0);
    pout <= 8'h00;
    pdir <= 8'hFE;
    @(posedge clk);
    check("pin enable", pin_oe, 8'hFE);
    check("released pin", lvl[1:0], 2'b01);
    test_done;
  end
endmodule // tb_top
